// file: tof_pixel_readout_regs.sv
// What this block does
// - imaging modes deliver interleaved even and odd 12-bit pixels on the pixel port.
// - top-half saturation byte: bit n flags column n as saturated.
// - bottom-half saturation byte uses the same column mapping.
// - per-column converter overflow flags, top and bottom bytes.
// - per-column converter underflow flags, top and bottom bytes.
// - once a double-row is read out, flags and data reload with the next.
// - summed results are 14, 15 or 18 bits wide by rangefinder mode.
// - unsigned output keeps the signed layout with unsigned values.
// - raw option strips embedded status from summed results.
// - status low six bits count bytes left in the current double-row.
// - status bit 7 mirrors the data-ready pin.
`timescale 1ns/1ps

module tof_row_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty
    assign full          = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign empty         = (wr_r == rd_r);
    assign push          = in_valid_in && !full;
    assign pop           = out_ready_in && !empty;
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = mem_r[rd_r[AW-1:0]];

    // pointers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end

    // storage needs no reset, empty flag guards it
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_data_in;
        end
    end

    a_fifo_bounds: assert property (@(posedge clk_in) disable iff (rst_in)
        full |=> !(wr_r != $past(wr_r)) || (rd_r != $past(rd_r)))
        else $error("fifo written while full");
endmodule : tof_row_fifo

module tof_pixel_readout_regs (
    input  wire logic                       CLK_IN,
    input  wire logic                       RST_IN,
    input  wire logic                       SCK_IN,
    input  wire logic                       CS_N_IN,
    input  wire logic                       MOSI_IN,
    output logic                            MISO_OUT,
    output logic                            MISO_OE_OUT,
    output logic                            DATA_RDY_OUT,
    input  wire tof_readout_pkg::mode_t     MODE_IN,
    input  wire logic                       UNSIGNED_IN,
    input  wire logic                       RAW_IN,
    input  wire logic [15:0]                TEMP_IN,
    input  wire logic                       TEMP_VALID_IN,
    input  wire tof_readout_pkg::row_flags_t FLAGS_IN,
    input  wire logic                       FLAGS_VALID_IN,
    input  wire logic                       ACQ_VALID_IN,
    input  wire tof_readout_pkg::acq_word_t ACQ_IN,
    output logic                            ACQ_READY_OUT
);
    import tof_readout_pkg::*;

    // link side, serial clock domain
    logic [4:0]  bit_cnt_r;
    logic [6:0]  sh_r;
    logic [6:0]  addr_hold_r;
    logic        req_sck_r;
    logic        ack_s1_r;
    logic        ack_s2_r;
    logic        ack_s3_r;
    logic [7:0]  out_r;

    // core side, CLK_IN domain
    logic        req_s1_r;
    logic        req_s2_r;
    logic        req_s3_r;
    logic        req_q_r;
    logic        ack_r;
    logic [7:0]  rd_data_r;
    logic [7:0]  rd_mux;
    logic [15:0] temp_r;
    row_flags_t  flags_r;
    row_flags_t  pend_r;
    logic [23:0] cur_r;
    logic [23:0] cur_nxt;
    logic [1:0]  idx_r;
    logic        have_r;
    logic [5:0]  rem_r;
    logic [5:0]  rem_nxt;

    logic        fifo_valid;
    acq_word_t   fifo_word;
    logic        imaging;
    logic        take;
    logic        active_port;
    logic        data_take;
    logic        pop;
    logic        row_start;
    logic [7:0]  cur_byte;
    logic [7:0]  status_byte;

    // pixel words wait here until the host drains them
    tof_row_fifo #(
        .WIDTH (ACQ_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (CLK_IN),
        .rst_in        (RST_IN),
        .in_valid_in   (ACQ_VALID_IN),
        .in_data_in    (ACQ_IN),
        .in_ready_out  (ACQ_READY_OUT),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_word),
        .out_ready_in  (pop)
    );

    // ---------------- serial clock domain ----------------

    // frame counter and address capture; chip select clears the frame
    always_ff @(posedge SCK_IN or posedge CS_N_IN) begin
        if (CS_N_IN) begin
            bit_cnt_r <= 5'h00;
            sh_r      <= 7'h00;
            req_sck_r <= 1'b0;
            ack_s1_r  <= 1'b0;
            ack_s2_r  <= 1'b0;
            ack_s3_r  <= 1'b0;
        end else begin
            sh_r      <= {sh_r[5:0], MOSI_IN};
            bit_cnt_r <= (bit_cnt_r == SPI_CNT_MAX) ? bit_cnt_r : bit_cnt_r + 5'h01;
            ack_s1_r  <= ack_r;
            ack_s2_r  <= ack_s1_r;
            ack_s3_r  <= ack_s2_r;
            if (bit_cnt_r == SPI_ADDR_LAST) begin
                req_sck_r <= !sh_r[6]; // registers are read-only: a write asks nothing
            end
        end
    end

    // address must not move while the core may still sample it
    always_ff @(posedge SCK_IN) begin
        if (!CS_N_IN && bit_cnt_r == SPI_ADDR_LAST) begin
            addr_hold_r <= {sh_r[5:0], MOSI_IN};
        end
    end

    // output byte changes on the falling edge, host samples on the rising
    always_ff @(negedge SCK_IN or posedge CS_N_IN) begin
        if (CS_N_IN) begin
            out_r <= 8'h00;
        end else if (bit_cnt_r == SPI_DATA_AT) begin
            out_r <= (ack_s2_r && ack_s3_r) ? rd_data_r : 8'h00; // late answer reads as zero
        end else begin
            out_r <= {out_r[6:0], 1'b0};
        end
    end

    assign MISO_OUT    = out_r[7];
    assign MISO_OE_OUT = !CS_N_IN;

    // ---------------- core domain ----------------

    // request level crosses with three flops; counts once the last two agree
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            req_q_r  <= 1'b0;
            ack_r    <= 1'b0;
        end else begin
            req_s1_r <= req_sck_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            if (req_s2_r == req_s3_r) begin
                req_q_r <= req_s3_r;
            end
            ack_r <= req_q_r;
        end
    end

    // decode of the accepted request
    assign imaging     = is_imaging(MODE_IN);
    assign take        = req_q_r && !ack_r;
    assign active_port = imaging ? (addr_hold_r == ADDR_PIXEL) : (addr_hold_r == ADDR_SUM);
    assign data_take   = take && active_port && have_r;
    assign pop         = !have_r && fifo_valid;
    assign row_start   = pop && (rem_r == 6'h00);
    assign cur_byte    = cur_r[8'(23 - 8 * idx_r) -: 8];
    assign status_byte = {have_r, 1'b0, rem_r};

    // imaging words pass as even then odd pixel; sums are sized per mode and sign-extended unless UNSIGNED_IN
    assign cur_nxt = imaging ? fifo_word.payload : sum_fmt(fifo_word, MODE_IN, UNSIGNED_IN, RAW_IN);
    assign rem_nxt = imaging ? ROW_BYTES_IMG : ROW_BYTES_SUM;

    // register read selection
    always_comb begin
        if (addr_hold_r == ADDR_TEMP_A) begin
            rd_mux = temp_r[7:0];
        end else if (addr_hold_r == ADDR_TEMP_B) begin
            rd_mux = temp_r[15:8];
        end else if (addr_hold_r == ADDR_SAT_TOP) begin
            rd_mux = flags_r.sat_top;
        end else if (addr_hold_r == ADDR_SAT_BOT) begin
            rd_mux = flags_r.sat_bot;
        end else if (addr_hold_r == ADDR_OVF_TOP) begin
            rd_mux = flags_r.ovf_top;
        end else if (addr_hold_r == ADDR_OVF_BOT) begin
            rd_mux = flags_r.ovf_bot;
        end else if (addr_hold_r == ADDR_UNF_TOP) begin
            rd_mux = flags_r.unf_top;
        end else if (addr_hold_r == ADDR_UNF_BOT) begin
            rd_mux = flags_r.unf_bot;
        end else if (addr_hold_r == ADDR_STATUS) begin
            rd_mux = status_byte;
        end else if (data_take) begin
            rd_mux = cur_byte;
        end else begin
            rd_mux = REG_RESET; // unmapped, idle or wrong-mode port
        end
    end

    // answer latch, stable while the acknowledge stands
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rd_data_r <= REG_RESET;
        end else if (take) begin
            rd_data_r <= rd_mux;
        end
    end

    // temperature and next-row flags captured from acquisition
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            temp_r <= 16'h0000;
            pend_r <= '0;
        end else begin
            if (TEMP_VALID_IN) begin
                temp_r <= TEMP_IN;
            end
            if (FLAGS_VALID_IN) begin
                pend_r <= FLAGS_IN;
            end
        end
    end

    // visible flags change only when a new double-row begins
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            flags_r <= '0;
        end else if (row_start) begin
            flags_r <= pend_r;
        end
    end

    // current word and byte pointer
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            cur_r  <= 24'h000000;
            idx_r  <= 2'h0;
            have_r <= 1'b0;
        end else if (pop) begin
            cur_r  <= cur_nxt;
            idx_r  <= 2'h0;
            have_r <= 1'b1;
        end else if (data_take) begin
            idx_r  <= idx_r + 2'h1;
            have_r <= (idx_r != WORD_LAST_BYTE);
        end
    end

    // bytes left in the double-row
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rem_r <= 6'h00;
        end else if (row_start) begin
            rem_r <= rem_nxt;
        end else if (data_take) begin
            rem_r <= rem_r - 6'h01;
        end
    end

    assign DATA_RDY_OUT = have_r;

    // ---------------- checks ----------------

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    sequence s_data_rd;
        data_take;
    endsequence

    sequence s_last_byte;
        data_take && (idx_r == WORD_LAST_BYTE);
    endsequence

    sequence s_sum_load;
        pop && !imaging;
    endsequence

    property p_flag_read(logic [6:0] a, logic [7:0] v);
        take && (addr_hold_r == a) |=> rd_data_r == $past(v);
    endproperty

    a_ack_once: assert property (take |=> ack_r && !take ##1 !take)
        else $error("request served twice");
    a_status_rdy: assert property (take && addr_hold_r == ADDR_STATUS |=>
        rd_data_r == {$past(have_r), 1'b0, $past(rem_r)})
        else $error("status byte wrong");
    a_rem_count: assert property (s_data_rd |=> rem_r == $past(rem_r) - 6'h01)
        else $error("remaining count not decremented");
    a_word_drain: assert property (s_last_byte |=> !have_r ##0 !DATA_RDY_OUT)
        else $error("word not released after last byte");
    a_row_reload: assert property (row_start |=> flags_r == $past(pend_r) && rem_r != 6'h00)
        else $error("row reload missed");
    a_sat_top: assert property (p_flag_read(ADDR_SAT_TOP, flags_r.sat_top))
        else $error("top saturation byte wrong");
    a_sat_bot: assert property (p_flag_read(ADDR_SAT_BOT, flags_r.sat_bot))
        else $error("bottom saturation byte wrong");
    a_ovf_top: assert property (p_flag_read(ADDR_OVF_TOP, flags_r.ovf_top))
        else $error("overflow byte wrong");
    a_unf_bot: assert property (p_flag_read(ADDR_UNF_BOT, flags_r.unf_bot))
        else $error("underflow byte wrong");
    a_pix_pair: assert property (pop && imaging |=> cur_r == $past(fifo_word.payload))
        else $error("pixel pair not loaded as is");
    a_sum_fast: assert property (s_sum_load and (MODE_IN == fast_rangefinder_mode && !UNSIGNED_IN)
        |=> cur_r[17:14] == {4{cur_r[13]}})
        else $error("fast sum not 14-bit signed");
    a_sum_uns: assert property (s_sum_load and (MODE_IN == high_dynamic_rangefinder_mode && UNSIGNED_IN)
        |=> cur_r[17:15] == 3'h0)
        else $error("unsigned sum extended");
    a_sum_raw: assert property ((s_sum_load and RAW_IN) |=> cur_r[23:18] == 6'h00)
        else $error("raw sum carries status");
endmodule : tof_pixel_readout_regs

// file: tof_pixel_readout_regs_tb_top.sv
`timescale 1ns/1ps

module tof_pixel_readout_regs_tb_top;
    import tof_readout_pkg::*;

    localparam logic [6:0] ALL_ADDR [12] = '{ADDR_TEMP_A, ADDR_TEMP_B, ADDR_PIXEL, ADDR_SAT_TOP, ADDR_SAT_BOT,
        ADDR_OVF_TOP, ADDR_OVF_BOT, ADDR_UNF_TOP, ADDR_UNF_BOT, ADDR_SUM, ADDR_STATUS, 7'h4f};
    localparam logic [6:0] FLAG_ADDR [6] = '{ADDR_SAT_TOP, ADDR_SAT_BOT, ADDR_OVF_TOP, ADDR_OVF_BOT,
        ADDR_UNF_TOP, ADDR_UNF_BOT};
    localparam mode_t SUM_MODE [3] = '{fast_rangefinder_mode, high_dynamic_rangefinder_mode,
        low_noise_rangefinder_mode};

    logic        CLK_IN;
    logic        RST_IN          = 1'b1;
    logic        SCK_IN;
    logic        CS_N_IN;
    logic        MOSI_IN;
    logic        MISO_OUT;
    logic        MISO_OE_OUT;
    logic        DATA_RDY_OUT;
    logic        ACQ_READY_OUT;
    mode_t       MODE_IN         = greyscale_imager_mode;
    logic        UNSIGNED_IN     = 1'b0;
    logic        RAW_IN          = 1'b0;
    logic [15:0] TEMP_IN         = 16'h0000;
    logic        TEMP_VALID_IN   = 1'b0;
    row_flags_t  FLAGS_IN        = '0;
    logic        FLAGS_VALID_IN  = 1'b0;
    logic        ACQ_VALID_IN    = 1'b0;
    acq_word_t   ACQ_IN          = '0;
    int          num_errors      = 0;
    int          samples_checked = 0;
    int          seed            = 73;
    acq_word_t   words[$];

    tof_pixel_readout_regs DUT (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .SCK_IN(SCK_IN), .CS_N_IN(CS_N_IN),
        .MOSI_IN(MOSI_IN), .MISO_OUT(MISO_OUT), .MISO_OE_OUT(MISO_OE_OUT), .DATA_RDY_OUT(DATA_RDY_OUT),
        .MODE_IN(MODE_IN), .UNSIGNED_IN(UNSIGNED_IN), .RAW_IN(RAW_IN), .TEMP_IN(TEMP_IN),
        .TEMP_VALID_IN(TEMP_VALID_IN), .FLAGS_IN(FLAGS_IN), .FLAGS_VALID_IN(FLAGS_VALID_IN),
        .ACQ_VALID_IN(ACQ_VALID_IN), .ACQ_IN(ACQ_IN), .ACQ_READY_OUT(ACQ_READY_OUT));

    tof_spi_host host (.sck_out(SCK_IN), .cs_n_out(CS_N_IN), .mosi_out(MOSI_IN), .miso_in(MISO_OUT));

    initial begin
        CLK_IN = 1'b0;
        forever #2 CLK_IN = ~CLK_IN;
    end

    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : check8

    task automatic rd_check(input string what, input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(cmd, d);
        check8(what, exp, d);
    endtask : rd_check

    task automatic check_flags(input row_flags_t f);
        for (int i = 0; i < 6; i++) rd_check("flags", {1'b0, FLAG_ADDR[i]}, f[47 - 8 * i -: 8]);
    endtask : check_flags

    // entered on a clock edge; valid stays up for the next call, caller lowers it
    task automatic push_word(input acq_word_t w, input int bound, output logic ok);
        int i;
        ok = 1'b0;
        ACQ_IN       <= w;
        ACQ_VALID_IN <= 1'b1;
        for (i = 0; i < bound && !ok; i++) begin
            @(posedge CLK_IN);
            ok = (ACQ_READY_OUT === 1'b1);
        end
        if (ok) words.push_back(w);
    endtask : push_word

    task automatic pulse_flags(input row_flags_t f);
        @(posedge CLK_IN);
        FLAGS_IN       <= f;
        FLAGS_VALID_IN <= 1'b1;
        @(posedge CLK_IN);
        FLAGS_VALID_IN <= 1'b0;
    endtask : pulse_flags

    function automatic acq_word_t rnd_word();
        logic [31:0] r;
        r = $random(seed);
        return r[25:0];
    endfunction : rnd_word

    function automatic logic [7:0] img_byte(acq_word_t w, int k);
        return w.payload[23 - 8 * k -: 8];
    endfunction : img_byte

    // value sized by mode, sign or zero filled up to 18 bits
    function automatic logic [23:0] sum_word(acq_word_t w, mode_t m, logic u, logic raw);
        logic [17:0] v;
        int          nb;
        nb = (m == fast_rangefinder_mode) ? 14 : (m == high_dynamic_rangefinder_mode) ? 15 : 18;
        for (int i = 0; i < 18; i++) v[i] = (i < nb) ? w.payload[i] : (!u && w.payload[nb - 1]);
        return {(raw ? 2'h0 : w.stat), 4'h0, v};
    endfunction : sum_word

    initial begin
        logic [63:0] r;
        logic [23:0] sw;
        logic        ok;
        int          n;
        row_flags_t  f1;
        row_flags_t  f2;
        acq_word_t   w;
        repeat (2) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        foreach (ALL_ADDR[i]) rd_check("reset", {1'b0, ALL_ADDR[i]}, REG_RESET);
        r  = {$random(seed), $random(seed)};
        f1 = r[47:0];
        r  = {$random(seed), $random(seed)};
        f2 = r[47:0];
        pulse_flags(f1);
        // fill until the buffer refuses; nobody reads meanwhile
        ok = 1'b1;
        n  = 0;
        while (ok && n < 40) begin
            push_word(rnd_word(), 3, ok);
            n++;
        end
        ACQ_VALID_IN <= 1'b0;
        check8("fill", 8'h01, {7'h0, words.size() >= FIFO_DEPTH});
        check8("acq_ready", 8'h00, {7'h0, ACQ_READY_OUT});
        check8("miso_oe", 8'h00, {7'h0, MISO_OE_OUT}); // select is high between frames
        rd_check("status", {1'b0, ADDR_STATUS}, {2'b10, ROW_BYTES_IMG});
        check_flags(f1);
        pulse_flags(f2);
        n = words.size();
        for (int k = 0; k < n; k++) begin
            w = words.pop_front();
            if (k == 8) check_flags(f2);
            for (int b = 0; b < 3; b++) rd_check("pixel", {1'b0, ADDR_PIXEL}, img_byte(w, b));
            if (k == 0) rd_check("status", {1'b0, ADDR_STATUS}, {2'b10, ROW_BYTES_IMG - 6'h03});
        end
        // the fill leaves a partial double-row; finish it so the count ends at zero
        for (int k = n % 8; k != 0 && k < 8; k++) begin
            @(posedge CLK_IN);
            push_word(rnd_word(), 20, ok);
            ACQ_VALID_IN <= 1'b0;
            if (!ok) begin
                num_errors++;
                final_report();
            end
            w = words.pop_front();
            for (int b = 0; b < 3; b++) rd_check("pixel_tail", {1'b0, ADDR_PIXEL}, img_byte(w, b));
        end
        rd_check("status_end", {1'b0, ADDR_STATUS}, 8'h00);
        check8("data_rdy", 8'h00, {7'h0, DATA_RDY_OUT});
        rd_check("pixel_empty", {1'b0, ADDR_PIXEL}, 8'h00);
        // temperature only after the image is read out
        r = $random(seed);
        @(posedge CLK_IN);
        TEMP_IN       <= r[15:0];
        TEMP_VALID_IN <= 1'b1;
        @(posedge CLK_IN);
        TEMP_VALID_IN <= 1'b0;
        rd_check("temp_a", {1'b0, ADDR_TEMP_A}, r[7:0]);
        rd_check("temp_b", {1'b0, ADDR_TEMP_B}, r[15:8]);
        rd_check("write", {1'b1, ADDR_TEMP_A}, 8'h00);
        // each rangefinder mode, first word with the sign bit of every width set
        for (int m = 0; m < 3; m++) begin
            @(posedge CLK_IN);
            MODE_IN     <= SUM_MODE[m];
            UNSIGNED_IN <= (m == 1);
            RAW_IN      <= (m == 2);
            @(posedge CLK_IN);
            push_word({2'h3, 24'h03e000}, 20, ok);
            for (int j = 0; j < 2 && ok; j++) push_word(rnd_word(), 20, ok);
            ACQ_VALID_IN <= 1'b0;
            if (!ok) begin
                num_errors++;
                final_report();
            end
            rd_check("sum_status", {1'b0, ADDR_STATUS}, {2'b10, ROW_BYTES_SUM});
            for (int j = 0; j < 3; j++) begin
                w  = words.pop_front();
                sw = sum_word(w, SUM_MODE[m], m == 1, m == 2);
                for (int b = 0; b < 3; b++) rd_check("sum", {1'b0, ADDR_SUM}, sw[23 - 8 * b -: 8]);
            end
        end
        final_report();
    end
endmodule : tof_pixel_readout_regs_tb_top

// file: tof_readout_pkg.sv
package tof_readout_pkg;

    // register addresses on the serial port, 7-bit space
    localparam logic [6:0] ADDR_TEMP_A    = 7'h4a;
    localparam logic [6:0] ADDR_TEMP_B    = 7'h4b;
    localparam logic [6:0] ADDR_PIXEL     = 7'h4c;
    localparam logic [6:0] ADDR_SAT_TOP   = 7'h4d;
    localparam logic [6:0] ADDR_SAT_BOT   = 7'h4e;
    localparam logic [6:0] ADDR_OVF_TOP   = 7'h50;
    localparam logic [6:0] ADDR_OVF_BOT   = 7'h51;
    localparam logic [6:0] ADDR_UNF_TOP   = 7'h52;
    localparam logic [6:0] ADDR_UNF_BOT   = 7'h53;
    localparam logic [6:0] ADDR_SUM       = 7'h54;
    localparam logic [6:0] ADDR_STATUS    = 7'h55;
    localparam logic [7:0] REG_RESET      = 8'h00;

    // readout geometry
    localparam logic [5:0] ROW_BYTES_IMG  = 6'h18;
    localparam logic [5:0] ROW_BYTES_SUM  = 6'h03;
    localparam logic [1:0] WORD_LAST_BYTE = 2'h2;
    localparam int         FIFO_DEPTH     = 32;
    localparam int         ACQ_WIDTH      = 26;

    // summed-result widths as masks: 14, 15 and 18 bits
    localparam logic [17:0] SUM_MASK_FAST = 18'h03fff;
    localparam logic [17:0] SUM_MASK_HDR  = 18'h07fff;
    localparam logic [17:0] SUM_MASK_LN   = 18'h3ffff;

    // serial frame: 8 address bits, 8 turnaround bits, 8 data bits
    localparam logic [4:0] SPI_ADDR_LAST  = 5'h07;
    localparam logic [4:0] SPI_DATA_AT    = 5'h10;
    localparam logic [4:0] SPI_CNT_MAX    = 5'h1f;

    typedef enum logic [5:0] {
        distance_imager_mode          = 6'h01,
        greyscale_imager_mode         = 6'h02,
        background_imager_mode        = 6'h04,
        fast_rangefinder_mode         = 6'h08,
        high_dynamic_rangefinder_mode = 6'h10,
        low_noise_rangefinder_mode    = 6'h20
    } mode_t;

    typedef struct packed {
        logic [1:0]  stat;
        logic [23:0] payload;
    } acq_word_t;

    typedef struct packed {
        logic [7:0] sat_top;
        logic [7:0] sat_bot;
        logic [7:0] ovf_top;
        logic [7:0] ovf_bot;
        logic [7:0] unf_top;
        logic [7:0] unf_bot;
    } row_flags_t;

    function automatic logic is_imaging(mode_t m);
        is_imaging = (m == distance_imager_mode) || (m == greyscale_imager_mode) ||
                     (m == background_imager_mode);
    endfunction : is_imaging

    // summed result: status in [23:22], value sized by mode in [17:0]
    function automatic logic [23:0] sum_fmt(acq_word_t w, mode_t m, logic uns, logic raw);
        logic [17:0] mask;
        logic [17:0] v;
        logic        sgn;
        mask = (m == fast_rangefinder_mode) ? SUM_MASK_FAST :
               (m == high_dynamic_rangefinder_mode) ? SUM_MASK_HDR : SUM_MASK_LN;
        v    = w.payload[17:0] & mask;
        sgn  = |(v & ~(mask >> 1));
        if (!uns && sgn) begin
            v = v | ~mask;
        end
        sum_fmt = {(raw ? 2'h0 : w.stat), 4'h0, v};
    endfunction : sum_fmt

endpackage : tof_readout_pkg

// file: tof_spi_host.sv
`timescale 1ns/1ps

// host side of the serial port; its clock stands still between frames
module tof_spi_host (
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      mosi_out,
    input  wire logic miso_in
);
    initial begin
        sck_out  = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // one register per frame: address, turnaround, then data sampled on rises
    task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data);
        int i;
        data     = 8'h00;
        cs_n_out = 1'b0;
        for (i = 0; i < 24; i++) begin
            // past the address the line toggles, so a stale bit is never mistaken
            mosi_out = (i < 8) ? cmd[7 - i] : ~mosi_out;
            #7.5 sck_out = 1'b1;
            if (i >= 16) data = {data[6:0], miso_in};
            #7.5 sck_out = 1'b0;
        end
        #7.5 cs_n_out = 1'b1;
        // select gap well above six core cycles
        #40;
    endtask : read_reg
endmodule : tof_spi_host
